// ===== hdl/cmit_pkg.sv
// Constants shared by the compare match interval timer files
// How it works
// (R01) Start register clears to zero at reset and standby entry, both channels stop.
// (R02) Start bit 1 runs channel one, bit 0 runs channel zero.
// (R03) Reserved bits of start and control/status registers read as zero.
// (R04) Each control/status register clears to zero at reset and standby entry.
// (R05) Match flag bit 7 reads one after match; write 0 clears, 1 keeps.
// (R06) Bit 6 enables the channel match interrupt while the flag is set.
// (R07) Clock select 00..11 picks peripheral clock divided by 8, 32, 128, 512.
// (R08) 16-bit up-counter steps once per selected tick while running, else holds.
// (R09) Counter equal to constant clears counter and sets the match flag.
// (R10) Counter resets to zero at reset and standby entry.
// (R11) Compare constant is 16 bits and initialises to all ones.
// (R12) Match with enable raises interrupt; counting resumes from zero by itself.
// (R13) Match is issued on the next counter tick after equality is reached.
// (R14) Match clear beats a simultaneous bus write to the counter.
// (R15) Bus write beats a simultaneous count-up; unwritten byte keeps its value.
// (R16) Software clears the flag by reading it as one, then writing zero; the code needs no read; a byte-0 bit-7 zero write clears it unless a match sets it.
// (R17) Divided clocks are one-cycle enables from a free-running prescaler.
package cmit_pkg;
	localparam int          DATA_W        = 16;
	localparam int          PRE_W         = 9;
	localparam logic [11:0] OFS_START     = 12'h000;
	localparam logic [11:0] OFS_CSR0      = 12'h004;
	localparam logic [11:0] OFS_CNT0      = 12'h008;
	localparam logic [11:0] OFS_COR0      = 12'h00C;
	localparam logic [11:0] OFS_CSR1      = 12'h014;
	localparam logic [11:0] OFS_CNT1      = 12'h018;
	localparam logic [11:0] OFS_COR1      = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h024;
	localparam int          FLAG_BIT      = 7;
	localparam int          IE_BIT        = 6;
	localparam logic [15:0] START_RST     = 16'h0000;
	localparam logic [15:0] CSR_RST       = 16'h0000;
	localparam logic [15:0] CNT_RST       = 16'h0000;
	localparam logic [15:0] COR_RST       = 16'hFFFF;
	localparam logic [15:0] CSR_WMASK     = 16'h0043;
	localparam logic [15:0] START_WMASK   = 16'h0003;
	localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
	localparam logic [8:0]  DIV8_MASK     = 9'h007;
	localparam logic [8:0]  DIV32_MASK    = 9'h01F;
	localparam logic [8:0]  DIV128_MASK   = 9'h07F;
	localparam logic [8:0]  DIV512_MASK   = 9'h1FF;
	typedef enum logic [1:0] {
		CMIT_DIV8,
		CMIT_DIV32,
		CMIT_DIV128,
		CMIT_DIV512
	} cmit_clk_sel_type;
endpackage

// ===== hdl/cmit_prescaler.sv
// Free-running prescaler giving one-cycle tick enables
`timescale 1ns/1ns
module cmit_prescaler
	import cmit_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        standby,
	output logic      [3:0]  tick
);
	logic [PRE_W-1:0] pre_r;

	// Standby restarts the phase so ticks line up with a fresh start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_r <= '0;
		else if (standby)
			pre_r <= '0;
		else
			pre_r <= pre_r + 1'b1;
	end

	// Each tick fires when the low bits are all ones: one cycle in N
	assign tick[0] = (pre_r & DIV8_MASK) == DIV8_MASK;     // R17
	assign tick[1] = (pre_r & DIV32_MASK) == DIV32_MASK;   // R17
	assign tick[2] = (pre_r & DIV128_MASK) == DIV128_MASK; // R17
	assign tick[3] = (pre_r & DIV512_MASK) == DIV512_MASK; // R17
endmodule // cmit_prescaler

// ===== hdl/cmit_channel.sv
// One timer channel: counter, compare constant and control/status
`timescale 1ns/1ns
module cmit_channel
	import cmit_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        standby,
	input  wire logic        run,
	input  wire logic [3:0]  tick,
	input  wire logic        csr_we,
	input  wire logic        cnt_we,
	input  wire logic        cor_we,
	input  wire logic [1:0]  wr_byte,
	input  wire logic [15:0] wdata,
	output logic      [15:0] csr_q,
	output logic      [15:0] cnt_q,
	output logic      [15:0] cor_q,
	output logic             match_evt
);
	logic [15:0]      cnt_r;
	logic [15:0]      cor_r;
	logic             flag_r;
	logic             ie_r;
	logic [1:0]       sel_r;
	logic             step;
	logic [15:0]      cnt_wr;
	cmit_clk_sel_type sel;

	assign sel = cmit_clk_sel_type'(sel_r);
	always_comb
	begin
		case (sel) // R07
			CMIT_DIV8:   step = tick[0];
			CMIT_DIV32:  step = tick[1];
			CMIT_DIV128: step = tick[2];
			CMIT_DIV512: step = tick[3];
			default:     step = 1'b0;
		endcase
	end

	// Match waits for the tick that would move the counter off equality
	assign match_evt = run && step && (cnt_r == cor_r); // R13

	always_comb
	begin
		cnt_wr = cnt_r;
		if (wr_byte[0])
			cnt_wr[7:0] = wdata[7:0]; // R15
		if (wr_byte[1])
			cnt_wr[15:8] = wdata[15:8]; // R15
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= CNT_RST; // R10
		else if (standby)
			cnt_r <= CNT_RST; // R10
		else if (match_evt)
			cnt_r <= CNT_RST; // R09 R12 R14
		else if (cnt_we)
			cnt_r <= cnt_wr; // R15
		else if (run && step)
			cnt_r <= cnt_r + 16'h0001; // R08
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cor_r <= COR_RST; // R11
		else if (standby)
			cor_r <= COR_RST; // R11
		else if (cor_we)
		begin
			if (wr_byte[0])
				cor_r[7:0] <= wdata[7:0];
			if (wr_byte[1])
				cor_r[15:8] <= wdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_r <= 1'b0; // R04
		else if (standby)
			flag_r <= 1'b0; // R04
		else if (match_evt)
			flag_r <= 1'b1; // R09
		else if (csr_we && wr_byte[0] && !wdata[FLAG_BIT])
			flag_r <= 1'b0; // R05 R16
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ie_r  <= 1'b0; // R04
			sel_r <= 2'h0;
		end
		else if (standby)
		begin
			ie_r  <= 1'b0; // R04
			sel_r <= 2'h0;
		end
		else if (csr_we && wr_byte[0])
		begin
			ie_r  <= wdata[IE_BIT];
			sel_r <= wdata[1:0]; // R07
		end
	end

	always_comb
	begin
		csr_q           = CSR_RST; // R03
		csr_q[FLAG_BIT] = flag_r; // R05
		csr_q[IE_BIT]   = ie_r; // R06
		csr_q[1:0]      = sel_r;
	end
	assign cnt_q = cnt_r;
	assign cor_q = cor_r;
endmodule // cmit_channel

// ===== hdl/cmit_timer.sv
// Two-channel compare match interval timer with APB register access
`timescale 1ns/1ns
module cmit_timer
	import cmit_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        standby,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [1:0]  match_interrupt_request,
	output logic             irq
);
	logic [1:0]  start_r;
	logic [1:0]  stat_r;
	logic [1:0]  mask_r;
	logic [3:0]  tick;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [1:0]  wr_byte;
	logic [15:0] wdata;
	logic [1:0]  match_evt;
	logic [15:0] csr_q [2];
	logic [15:0] cnt_q [2];
	logic [15:0] cor_q [2];
	logic [15:0] rd_val;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign wr_byte = pstrb[1:0];
	assign wdata   = pwdata[15:0];
	// Zero wait state keeps the counter write race fixed to one edge
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	cmit_prescaler i_cmit_prescaler
	(
		.pclk    (pclk),
		.presetn (presetn),
		.standby (standby),
		.tick    (tick)
	);

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			logic [11:0] base;
			assign base = (ch == 0) ? 12'h000 : 12'h010;
			cmit_channel i_cmit_channel
			(
				.pclk      (pclk),
				.presetn   (presetn),
				.standby   (standby),
				.run       (start_r[ch]), // R02
				.tick      (tick),
				.csr_we    (wr_en && paddr == OFS_CSR0 + base),
				.cnt_we    (wr_en && paddr == OFS_CNT0 + base),
				.cor_we    (wr_en && paddr == OFS_COR0 + base),
				.wr_byte   (wr_byte),
				.wdata     (wdata),
				.csr_q     (csr_q[ch]),
				.cnt_q     (cnt_q[ch]),
				.cor_q     (cor_q[ch]),
				.match_evt (match_evt[ch])
			);
			// Request stays up while flag and enable are both set
			assign match_interrupt_request[ch] =
				csr_q[ch][FLAG_BIT] && csr_q[ch][IE_BIT]; // R06 R12
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			start_r <= START_RST[1:0]; // R01
		else if (standby)
			start_r <= START_RST[1:0]; // R01
		else if (wr_en && paddr == OFS_START && wr_byte[0])
			start_r <= wdata[1:0] & START_WMASK[1:0]; // R02
	end

	// Sticky summary status; a new match wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_r <= 2'h0;
		else if (standby)
			stat_r <= 2'h0;
		else if (wr_en && paddr == OFS_IRQ_STAT && wr_byte[0])
			stat_r <= (stat_r & ~wdata[1:0]) | match_evt;
		else
			stat_r <= stat_r | match_evt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_r <= IRQ_MASK_RST;
		else if (wr_en && paddr == OFS_IRQ_MASK && wr_byte[0])
			mask_r <= wdata[1:0];
	end

	assign irq = |(stat_r & mask_r);

	always_comb
	begin
		hit    = 1'b1;
		rd_val = 16'h0000; // R03
		case (paddr)
			OFS_START:    rd_val = {14'h0000, start_r}; // R03
			OFS_CSR0:     rd_val = csr_q[0];
			OFS_CNT0:     rd_val = cnt_q[0];
			OFS_COR0:     rd_val = cor_q[0];
			OFS_CSR1:     rd_val = csr_q[1];
			OFS_CNT1:     rd_val = cnt_q[1];
			OFS_COR1:     rd_val = cor_q[1];
			OFS_IRQ_STAT: rd_val = {14'h0000, stat_r};
			OFS_IRQ_MASK: rd_val = {14'h0000, mask_r};
			default:      hit = 1'b0;
		endcase
	end

	// Read data is captured at the setup edge so that it stands through
	// the access cycle, where the master takes it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= {16'h0000, rd_val}; // R03
	end
endmodule // cmit_timer

// ===== tb/cmit_timer_sva.sv
// Port-level properties of the interval timer
`timescale 1ns/1ns
module cmit_timer_sva
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        standby,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  match_interrupt_request
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire map = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h014,
		12'h018, 12'h01C, 12'h020, 12'h024};
	sequence s_rd(a);
		acc && !pwrite && paddr == a;
	endsequence
	a_zero_wait: assert property (psel |-> pready)
		else $error("pready low in a transfer");
	a_err_unmapped: assert property (acc && !map |-> pslverr)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && map |-> !pslverr)
		else $error("error on mapped access");
	a_rd_unmapped: assert property (acc && !pwrite && !map |-> prdata == 0)
		else $error("unmapped read not zero");
	a_start_rsv: assert property (s_rd(12'h000) |-> prdata[31:2] == 0)
		else $error("start reserved bits set");
	a_csr_rsv: assert property (s_rd(12'h004) or s_rd(12'h014) |->
		(prdata & 32'hFFFFFF3C) == 0)
		else $error("status reserved bits set");
	a_cnt_width: assert property (s_rd(12'h008) or s_rd(12'h018) or
		s_rd(12'h00C) or s_rd(12'h01C) |-> prdata[31:16] == 0)
		else $error("counter read wider than 16 bits");
	a_standby_quiet: assert property (standby |=>
		match_interrupt_request == 2'b00)
		else $error("request survives standby");
endmodule // cmit_timer_sva
bind cmit_timer cmit_timer_sva i_sva (.pclk, .presetn, .standby, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.match_interrupt_request);

// ===== tb/cmit_intc_model.sv
// Interrupt controller stand-in counting accepted requests
`timescale 1ns/1ns
module cmit_intc_model
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic irq,
	output int unsigned taken
);
	logic irq_r;
	// A held level is one request, so only rises are counted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_r <= 1'b0;
			taken <= 0;
		end
		else
		begin
			irq_r <= irq;
			if (irq && !irq_r)
				taken <= taken + 1;
		end
	end
endmodule // cmit_intc_model

// ===== tb/cmit_timer_tb_top.sv
// Self-checking bench for the interval timer
`timescale 1ns/1ns
module cmit_timer_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        standby = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  match_interrupt_request;
	logic        irq;
	logic [31:0] seed = 32'h10;
	logic [31:0] exp_q[$];
	logic [15:0] r;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          t0;
	int          t1;
	int unsigned taken;
	logic [11:0] ra[8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h014,
		12'h018, 12'h01C, 12'h024};
	logic [31:0] re[8] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0,
		32'hFFFF, 32'h0};
	cmit_timer i_cmit_timer (.pclk, .presetn, .standby, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.match_interrupt_request, .irq);
	cmit_intc_model i_cmit_intc_model (.pclk, .presetn, .irq, .taken);
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk)
		cyc <= cyc + 1;
	function automatic logic [15:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wrap_up();
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic wait_req(output int t);
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		while (match_interrupt_request[0] !== 1'b1 && n < 2000);
		t = cyc;
	endtask
	// Read data stands in the access cycle and is taken at its closing edge
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
			chk("prdata", exp_q.pop_front(), prdata);
	end
	initial
	begin
		#(40 * 40000);
		num_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			foreach (ra[i])
				rd(ra[i], re[i]);
			apb(12'h000, 1'b1, 32'h3);
			apb(12'h00C, 1'b1, 32'h5);
			apb(12'h004, 1'b1, 32'h43);
			@(posedge pclk);
			standby <= 1'b1;
			@(posedge pclk);
			standby <= 1'b0;
		end
		apb(12'h000, 1'b1, 32'hFFFE);
		rd(12'h000, 32'h2);
		apb(12'h014, 1'b1, 32'hFFFF);
		rd(12'h014, 32'h43);
		apb(12'h000, 1'b1, 32'h0);
		r = xs();
		apb(12'h018, 1'b1, {16'h0, r});
		pstrb <= 4'h1;
		apb(12'h018, 1'b1, {16'h0, ~r});
		pstrb <= 4'hF;
		rd(12'h018, {16'h0, r[15:8], ~r[7:0]});
		r = xs();
		apb(12'h01C, 1'b1, {16'h0, r});
		rd(12'h01C, {16'h0, r});
		apb(12'h024, 1'b1, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			apb(12'h00C, 1'b1, 32'h1);
			apb(12'h008, 1'b1, 32'h0);
			apb(12'h004, 1'b1, 32'h40 | k);
			apb(12'h000, 1'b1, 32'h1);
			wait_req(t0);
			rd(12'h004, 32'hC0 | k);
			chk("irq", 32'h1, irq);
			apb(12'h020, 1'b1, 32'h1);
			apb(12'h004, 1'b1, 32'h40 | k);
			#1;
			chk("req", 32'h0, match_interrupt_request[0]);
			wait_req(t1);
			chk("interval", 16 << (2 * k), t1 - t0);
			apb(12'h004, 1'b1, k);
			repeat (20 << (2 * k)) @(posedge pclk);
			#1;
			chk("req", 32'h0, match_interrupt_request[0]);
			rd(12'h004, 32'h80 | k);
			apb(12'h000, 1'b1, 32'h0);
		end
		apb(12'h024, 1'b1, 32'h0);
		#1;
		chk("irq", 32'h0, irq);
		chk("taken", 32'h1, taken >= 4);
		rd(12'h030, 32'h0);
		repeat (2) @(posedge pclk);
		wrap_up();
	end
endmodule // cmit_timer_tb_top
